// *** rtl/hbes_pkg.sv ***
/*
 * Package for the host bridge byte-order block: widths, lane masks,
 * mode encodings and reset values shared by both ends.
 * Assumes a single 200 MHz clock and an active-low asynchronous reset.
 */
package hbes_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int LANES = 8;
	localparam int LOW_BITS = 3;

	typedef enum logic [1:0]
	{
		HBES_SZ_BYTE = 2'b00,
		HBES_SZ_HALF = 2'b01,
		HBES_SZ_WORD = 2'b10,
		HBES_SZ_DWORD = 2'b11
	} hbes_size_e;

	typedef enum logic
	{
		HBES_MODE_BIG = 1'b0,
		HBES_MODE_LITTLE = 1'b1
	} hbes_mode_e;

	// size-dependent masks for low address bits
	localparam logic [2:0] MASK_BYTE = 3'h7;
	localparam logic [2:0] MASK_HALF = 3'h6;
	localparam logic [2:0] MASK_WORD = 3'h4;
	localparam logic [2:0] MASK_DWORD = 3'h0;

	localparam logic RST_VALID = 1'b0;
	localparam logic [ADDR_W-1:0] RST_ADDR = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_DATA = 64'h0000_0000_0000_0000;
	localparam logic [LANES-1:0] RST_BE = 8'h00;
	localparam hbes_mode_e RST_MODE = HBES_MODE_BIG;
endpackage

// *** rtl/hbes_link_if.sv ***
/*
 * Interface between the processor-side end and the bridge end.
 * Carries one processor-bus request path, a valid/ready handshake,
 * plus the shared mode; assumes a shared clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface hbes_link_if;
	// processor-bus side, always big-endian byte order
	logic cpu_valid;
	logic cpu_ready;
	logic cpu_write;
	logic [hbes_pkg::ADDR_W-1:0] cpu_addr;
	hbes_pkg::hbes_size_e cpu_size;
	logic [hbes_pkg::DATA_W-1:0] cpu_data;
	logic [hbes_pkg::LANES-1:0] cpu_be;
	// mode shared by both ends
	hbes_pkg::hbes_mode_e mode;

	modport cpu
	(
		output cpu_valid, cpu_write, cpu_addr, cpu_size, cpu_data, cpu_be,
		output mode,
		input cpu_ready
	);
	modport bridge
	(
		input cpu_valid, cpu_write, cpu_addr, cpu_size, cpu_data, cpu_be,
		input mode,
		output cpu_ready
	);
endinterface
`default_nettype wire

// *** rtl/hbes_cpu_end.sv ***
/*
 * Processor end: takes program-order accesses in the selected endian
 * mode and presents them on the link in big-endian bus convention.
 * Assumes the bridge end answers ready in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module hbes_cpu_end
(
	// clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_ce,
	// mode strap from software setup
	input wire logic i_little,
	// user request
	input wire logic i_valid,
	input wire logic i_write,
	input wire logic [hbes_pkg::ADDR_W-1:0] i_addr,
	input wire hbes_pkg::hbes_size_e i_size,
	input wire logic [hbes_pkg::DATA_W-1:0] i_data,
	output logic o_ready,
	// link
	hbes_link_if.cpu link
);
	logic valid_r;
	logic write_r;
	logic [hbes_pkg::ADDR_W-1:0] addr_r;
	hbes_pkg::hbes_size_e size_r;
	logic [hbes_pkg::DATA_W-1:0] data_r;
	logic [hbes_pkg::LANES-1:0] be_r;
	hbes_pkg::hbes_mode_e mode_r;

	function automatic logic [2:0] lane_mask(input hbes_pkg::hbes_size_e s);
		case (s)
			hbes_pkg::HBES_SZ_BYTE: lane_mask = hbes_pkg::MASK_BYTE;
			hbes_pkg::HBES_SZ_HALF: lane_mask = hbes_pkg::MASK_HALF;
			hbes_pkg::HBES_SZ_WORD: lane_mask = hbes_pkg::MASK_WORD;
			default: lane_mask = hbes_pkg::MASK_DWORD;
		endcase
	endfunction

	function automatic logic [7:0] size_be(input hbes_pkg::hbes_size_e s,
		input logic [2:0] a);
		case (s)
			hbes_pkg::HBES_SZ_BYTE: size_be = 8'h01 << a;
			hbes_pkg::HBES_SZ_HALF: size_be = 8'h03 << {a[2:1], 1'b0};
			hbes_pkg::HBES_SZ_WORD: size_be = 8'h0F << {a[2], 2'b00};
			default: size_be = 8'hFF;
		endcase
	endfunction

	assign o_ready = !valid_r || link.cpu_ready;

	// mode rides with each request taken, so a held one never splits
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			mode_r <= hbes_pkg::RST_MODE;
		else if (i_ce && o_ready)
			mode_r <= i_little ? hbes_pkg::HBES_MODE_LITTLE
				: hbes_pkg::HBES_MODE_BIG;
	end

	// little mode: rearrange low address so bus stays big-endian
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			valid_r <= hbes_pkg::RST_VALID;
			write_r <= 1'b0;
			addr_r <= hbes_pkg::RST_ADDR;
			size_r <= hbes_pkg::HBES_SZ_BYTE;
			data_r <= hbes_pkg::RST_DATA;
			be_r <= hbes_pkg::RST_BE;
		end
		else if (i_ce && o_ready)
		begin
			valid_r <= i_valid;
			if (i_valid)
			begin
				write_r <= i_write;
				size_r <= i_size;
				data_r <= i_data;
				if (i_little)
				begin
					addr_r <= {i_addr[hbes_pkg::ADDR_W-1:3],
						i_addr[2:0] ^ lane_mask(i_size)};
					be_r <= size_be(i_size, i_addr[2:0] ^ lane_mask(i_size));
				end
				else
				begin
					addr_r <= i_addr;
					be_r <= size_be(i_size, i_addr[2:0]);
				end
			end
		end
	end

	assign link.cpu_valid = valid_r;
	assign link.cpu_write = write_r;
	assign link.cpu_addr = addr_r;
	assign link.cpu_size = size_r;
	assign link.cpu_data = data_r;
	assign link.cpu_be = be_r;
	assign link.mode = mode_r;
endmodule
`default_nettype wire

// *** rtl/hbes_bridge_end.sv ***
/*
 * Bridge end: host bridge byte-order logic plus the VME bridge lane
 * swap. Processor accesses go to local (big-endian) space or PCI;
 * PCI masters reach memory; VME traffic crosses to and from PCI.
 * Assumes every user port is on i_mclk; one request per path.
 * i_vx_to_pci only tags direction: the swap is its own inverse.
 */
`timescale 1ns/1ps
`default_nettype none
module hbes_bridge_end
#(
	parameter int PCI_BASE = 32'h8000_0000
)
(
	// clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_ce,
	// link from processor end
	hbes_link_if.bridge link,
	// processor access out to local space, big-endian
	output logic o_loc_valid,
	output logic o_loc_write,
	output logic [hbes_pkg::ADDR_W-1:0] o_loc_addr,
	output logic [hbes_pkg::DATA_W-1:0] o_loc_data,
	output logic [hbes_pkg::LANES-1:0] o_loc_be,
	// processor access out to PCI, little-endian
	output logic o_pci_valid,
	output logic o_pci_write,
	output logic [hbes_pkg::ADDR_W-1:0] o_pci_addr,
	output logic [hbes_pkg::DATA_W-1:0] o_pci_data,
	output logic [hbes_pkg::LANES-1:0] o_pci_be,
	input wire logic i_down_ready,
	// PCI master toward memory
	input wire logic i_pm_valid,
	input wire logic [hbes_pkg::ADDR_W-1:0] i_pm_addr,
	input wire hbes_pkg::hbes_size_e i_pm_size,
	input wire logic [hbes_pkg::DATA_W-1:0] i_pm_data,
	output logic o_mem_valid,
	output logic [hbes_pkg::ADDR_W-1:0] o_mem_addr,
	output logic [hbes_pkg::DATA_W-1:0] o_mem_data,
	// VME bridge, either direction, always swapped
	input wire logic i_vx_valid,
	input wire logic i_vx_to_pci,
	input wire logic [hbes_pkg::DATA_W-1:0] i_vx_data,
	output logic o_vx_valid,
	output logic [hbes_pkg::DATA_W-1:0] o_vx_data
);
	logic busy_r;
	logic is_pci;
	logic [2:0] mask;
	logic [2:0] pm_mask;
	logic little;

	function automatic logic [2:0] lane_mask(input hbes_pkg::hbes_size_e s);
		case (s)
			hbes_pkg::HBES_SZ_BYTE: lane_mask = hbes_pkg::MASK_BYTE;
			hbes_pkg::HBES_SZ_HALF: lane_mask = hbes_pkg::MASK_HALF;
			hbes_pkg::HBES_SZ_WORD: lane_mask = hbes_pkg::MASK_WORD;
			default: lane_mask = hbes_pkg::MASK_DWORD;
		endcase
	endfunction

	// full byte-lane reversal, lane i to lane 7-i
	function automatic logic [63:0] swap64(input logic [63:0] d);
		for (int i = 0; i < 8; i++)
			swap64[i*8 +: 8] = d[(7-i)*8 +: 8];
	endfunction

	function automatic logic [7:0] swap_be(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			swap_be[i] = b[7-i];
	endfunction

	assign little = (link.mode == hbes_pkg::HBES_MODE_LITTLE);
	// lane masks for the link request and the PCI master request
	assign mask = lane_mask(link.cpu_size);
	assign pm_mask = lane_mask(i_pm_size);
	// everything at or above the base goes out to PCI
	assign is_pci = (link.cpu_addr >= PCI_BASE[hbes_pkg::ADDR_W-1:0]);
	// one outstanding request; downstream stall holds the link
	assign link.cpu_ready = !busy_r || i_down_ready;

	// local space never swapped, always big-endian
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_loc_valid <= hbes_pkg::RST_VALID;
			o_loc_write <= 1'b0;
			o_loc_addr <= hbes_pkg::RST_ADDR;
			o_loc_data <= hbes_pkg::RST_DATA;
			o_loc_be <= hbes_pkg::RST_BE;
		end
		else if (i_ce && link.cpu_ready)
		begin
			o_loc_valid <= link.cpu_valid && !is_pci;
			o_loc_write <= link.cpu_write;
			o_loc_addr <= link.cpu_addr;
			o_loc_data <= link.cpu_data;
			o_loc_be <= link.cpu_be;
		end
	end

	// PCI-bound flags follow the link one for one
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_pci_valid <= hbes_pkg::RST_VALID;
			o_pci_write <= 1'b0;
		end
		else if (i_ce && link.cpu_ready)
		begin
			o_pci_valid <= link.cpu_valid && is_pci;
			o_pci_write <= link.cpu_write;
		end
	end

	// little mode undoes the processor's rearrangement on the way out
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_pci_addr <= hbes_pkg::RST_ADDR;
		else if (i_ce && link.cpu_ready)
		begin
			if (little)
				o_pci_addr <= {link.cpu_addr[hbes_pkg::ADDR_W-1:3],
					link.cpu_addr[2:0] ^ mask};
			else
				o_pci_addr <= link.cpu_addr;
		end
	end

	// big mode swaps data; enables go to PCI lane order in both modes
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_pci_data <= hbes_pkg::RST_DATA;
			o_pci_be <= hbes_pkg::RST_BE;
		end
		else if (i_ce && link.cpu_ready)
		begin
			o_pci_data <= little ? link.cpu_data
				: swap64(link.cpu_data);
			o_pci_be <= swap_be(link.cpu_be);
		end
	end

	// tracks an outstanding downstream request
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			busy_r <= 1'b0;
		else if (i_ce && link.cpu_ready)
			busy_r <= link.cpu_valid;
	end

	// PCI master valid is a one-cycle stage, no backpressure
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_mem_valid <= hbes_pkg::RST_VALID;
		else if (i_ce)
			o_mem_valid <= i_pm_valid;
	end

	// PCI master to memory: swap or rearrange by mode
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_mem_addr <= hbes_pkg::RST_ADDR;
			o_mem_data <= hbes_pkg::RST_DATA;
		end
		else if (i_ce)
		begin
			if (little)
			begin
				o_mem_addr <= {i_pm_addr[hbes_pkg::ADDR_W-1:3],
					i_pm_addr[2:0] ^ pm_mask};
				o_mem_data <= i_pm_data;
			end
			else
			begin
				o_mem_addr <= i_pm_addr;
				o_mem_data <= swap64(i_pm_data);
			end
		end
	end

	// VME lanes swapped regardless of mode, so the host swap cancels it
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_vx_valid <= hbes_pkg::RST_VALID;
			o_vx_data <= hbes_pkg::RST_DATA;
		end
		else if (i_ce)
		begin
			o_vx_valid <= i_vx_valid;
			o_vx_data <= swap64(i_vx_data);
		end
	end
endmodule
`default_nettype wire

// *** testbench/hbes_link_sva.sv ***
/*
 * Link checker: request hold and lane enables on the processor link.
 * Assumes the bench top feeds it the link signals, clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none
module hbes_link_sva
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// link signals
	input wire logic cpu_valid,
	input wire logic cpu_ready,
	input wire logic [hbes_pkg::ADDR_W-1:0] cpu_addr,
	input wire hbes_pkg::hbes_size_e cpu_size,
	input wire logic [hbes_pkg::DATA_W-1:0] cpu_data,
	input wire logic [hbes_pkg::LANES-1:0] cpu_be,
	input wire hbes_pkg::hbes_mode_e mode
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	// a request left waiting, then seen again next cycle
	sequence s_wait;
		cpu_valid && !cpu_ready;
	endsequence
	sequence s_kept;
		cpu_valid && $stable(cpu_addr) && $stable(cpu_size);
	endsequence
	property p_hold;
		s_wait |=> s_kept;
	endproperty
	property p_data;
		s_wait |=> $stable(cpu_data);
	endproperty
	// mode may only move between requests, never under one
	property p_mode;
		s_wait |=> $stable(mode);
	endproperty
	property p_be_hold;
		s_wait ##1 s_wait |-> $stable(cpu_be);
	endproperty
	// enables follow size and the low address bits as sent
	property p_byte;
		cpu_valid && cpu_size == hbes_pkg::HBES_SZ_BYTE |->
			cpu_be == 8'h01 << cpu_addr[2:0];
	endproperty
	property p_half;
		cpu_valid && cpu_size == hbes_pkg::HBES_SZ_HALF |->
			cpu_be == 8'h03 << {cpu_addr[2:1], 1'b0};
	endproperty
	property p_word;
		cpu_valid && cpu_size == hbes_pkg::HBES_SZ_WORD |->
			cpu_be == 8'h0F << {cpu_addr[2], 2'b00};
	endproperty
	property p_dword;
		cpu_valid && cpu_size == hbes_pkg::HBES_SZ_DWORD |-> cpu_be == 8'hFF;
	endproperty
	a_hold: assert property (p_hold) else $error("link request moved");
	a_data: assert property (p_data) else $error("link data moved");
	a_mode: assert property (p_mode) else $error("mode moved");
	a_be_hold: assert property (p_be_hold) else $error("be moved");
	a_byte: assert property (p_byte) else $error("byte enables");
	a_half: assert property (p_half) else $error("half enables");
	a_word: assert property (p_word) else $error("word enables");
	a_dword: assert property (p_dword) else $error("dword enables");
endmodule
`default_nettype wire

// *** testbench/hbes_bench.sv ***
/*
 * Bench for both ends joined by the link: table of processor
 * accesses to PCI, then local, PCI master and VME cases by hand.
 * Assumes a 200 MHz clock and active-low reset held six cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module hbes_bench;
	typedef struct packed {logic lit; logic [1:0] sz; logic [31:0] a;
		logic [7:0] be;} hbes_row_s;
	localparam logic [63:0] D = 64'h0011_2233_4455_6677;
	logic i_mclk, i_nrst, i_little, i_valid, i_write, o_ready;
	logic o_loc_valid, o_pci_valid, i_down_ready, i_pm_valid, o_mem_valid;
	logic o_loc_write, o_pci_write;
	logic i_vx_valid, i_vx_to_pci, o_vx_valid;
	logic [31:0] i_addr, o_loc_addr, o_pci_addr, i_pm_addr, o_mem_addr;
	logic [63:0] i_data, o_loc_data, o_pci_data, i_pm_data, o_mem_data;
	logic [63:0] i_vx_data, o_vx_data;
	logic [7:0] o_loc_be, o_pci_be;
	hbes_pkg::hbes_size_e i_size, i_pm_size;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	// every size in big mode, all but dword in little mode; pci address comes back unchanged
	hbes_row_s rows [7] = '{'{1'b0, 2'h0, 32'h8000_0003, 8'h10},
		'{1'b0, 2'h1, 32'h8000_0002, 8'h30}, '{1'b0, 2'h2, 32'h8000_0004, 8'h0F},
		'{1'b0, 2'h3, 32'h8000_0008, 8'hFF}, '{1'b1, 2'h0, 32'h8000_0003, 8'h08},
		'{1'b1, 2'h1, 32'h8000_0002, 8'h0C}, '{1'b1, 2'h2, 32'h8000_0004, 8'hF0}};
	hbes_link_if link();
	hbes_cpu_end hbes_cpu_end_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(1'b1),
		.i_little(i_little), .i_valid(i_valid), .i_write(i_write),
		.i_addr(i_addr), .i_size(i_size), .i_data(i_data), .o_ready(o_ready),
		.link(link));
	hbes_bridge_end hbes_bridge_end_i (.i_mclk(i_mclk), .i_nrst(i_nrst),
		.i_ce(1'b1), .link(link), .o_loc_valid(o_loc_valid),
		.o_loc_write(o_loc_write),
		.o_loc_addr(o_loc_addr), .o_loc_data(o_loc_data), .o_loc_be(o_loc_be),
		.o_pci_valid(o_pci_valid), .o_pci_write(o_pci_write),
		.o_pci_addr(o_pci_addr),
		.o_pci_data(o_pci_data), .o_pci_be(o_pci_be),
		.i_down_ready(i_down_ready), .i_pm_valid(i_pm_valid),
		.i_pm_addr(i_pm_addr), .i_pm_size(i_pm_size), .i_pm_data(i_pm_data),
		.o_mem_valid(o_mem_valid), .o_mem_addr(o_mem_addr),
		.o_mem_data(o_mem_data), .i_vx_valid(i_vx_valid),
		.i_vx_to_pci(i_vx_to_pci), .i_vx_data(i_vx_data),
		.o_vx_valid(o_vx_valid), .o_vx_data(o_vx_data));
	hbes_link_sva hbes_link_sva_i (.i_mclk(i_mclk), .i_nrst(i_nrst),
		.cpu_valid(link.cpu_valid), .cpu_ready(link.cpu_ready),
		.cpu_addr(link.cpu_addr), .cpu_size(link.cpu_size),
		.cpu_data(link.cpu_data), .cpu_be(link.cpu_be), .mode(link.mode));
	// free-running clock
	initial
	begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	// hang guard, well above the fewer than one hundred cycles needed
	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			error_cnt++;
			finish_test();
		end
	end
	function automatic logic [63:0] swap(input logic [63:0] v);
		for (int i = 0; i < 8; i++)
			swap[8*i +: 8] = v[56-8*i +: 8];
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic check(input string n, input logic [63:0] got, exp);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", n, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d, errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// drain the last access, then stall downstream so the output stands
	task automatic cpu_op(input logic lit, input logic [1:0] sz,
		input logic [31:0] a);
		i_down_ready = 1'b1;
		step(2);
		i_down_ready = 1'b0;
		i_little = lit;
		i_valid = 1'b1;
		i_size = hbes_pkg::hbes_size_e'(sz);
		i_addr = a;
		step(1);
		i_valid = 1'b0;
		step(3);
	endtask
	task automatic pm(input logic lit, input logic [1:0] sz,
		input logic [31:0] a, ea, input logic [63:0] d, ed);
		i_little = lit;
		i_down_ready = 1'b1;
		step(2);
		i_pm_valid = 1'b1;
		i_pm_size = hbes_pkg::hbes_size_e'(sz);
		i_pm_addr = a;
		i_pm_data = d;
		step(1);
		i_pm_valid = 1'b0;
		check("mem valid", o_mem_valid, 1'b1);
		check("mem addr", o_mem_addr, ea);
		check("mem data", o_mem_data, ed);
	endtask
	// main sequence
	initial
	begin
		{i_nrst, i_little, i_valid, i_write, i_down_ready} = '0;
		{i_pm_valid, i_vx_valid, i_vx_to_pci} = '0;
		i_size = hbes_pkg::HBES_SZ_BYTE;
		i_pm_size = hbes_pkg::HBES_SZ_BYTE;
		{i_addr, i_pm_addr, i_pm_data} = '0;
		i_data = D;
		i_vx_data = D;
		step(6);
		check("rst valid", link.cpu_valid, 1'b0);
		check("rst mode", link.mode, hbes_pkg::HBES_MODE_BIG);
		i_nrst = 1'b1;
		i_write = 1'b1;
		step(1);
		check("ready", o_ready, 1'b1);
		foreach (rows[k])
		begin
			cpu_op(rows[k].lit, rows[k].sz, rows[k].a);
			check("pci valid", o_pci_valid, 1'b1);
			check("pci write", o_pci_write, 1'b1);
			check("pci addr", o_pci_addr, rows[k].a);
			check("pci data", o_pci_data, rows[k].lit ? D : swap(D));
			check("pci be", o_pci_be, rows[k].be);
		end
		// a second request behind a stalled one waits on the link
		i_little = 1'b0;
		i_valid = 1'b1;
		i_size = hbes_pkg::HBES_SZ_WORD;
		i_addr = 32'h0000_2004;
		step(1);
		i_valid = 1'b0;
		step(2);
		check("link held", link.cpu_valid, 1'b1);
		check("refused", o_ready, 1'b0);
		check("held addr", link.cpu_addr, 32'h0000_2004);
		i_down_ready = 1'b1;
		step(1);
		check("stall loc valid", o_loc_valid, 1'b1);
		check("stall loc addr", o_loc_addr, 32'h0000_2004);
		check("stall loc be", o_loc_be, 8'hF0);
		cpu_op(1'b1, 2'h3, 32'h0000_1000);
		check("loc valid", o_loc_valid, 1'b1);
		check("loc write", o_loc_write, 1'b1);
		check("loc addr", o_loc_addr, 32'h0000_1000);
		check("loc data", o_loc_data, D);
		check("loc be", o_loc_be, 8'hFF);
		pm(1'b0, 2'h0, 32'h10, 32'h10, D, swap(D));
		pm(1'b1, 2'h0, 32'h10, 32'h17, D, D);
		pm(1'b1, 2'h1, 32'h12, 32'h14, D, D);
		pm(1'b1, 2'h2, 32'h04, 32'h00, D, D);
		// vme lanes swap whichever way and whatever the mode
		for (int k = 0; k < 2; k++)
		begin
			i_vx_to_pci = k[0];
			i_little = k[0];
			i_vx_valid = 1'b1;
			step(1);
			i_vx_valid = 1'b0;
			check("vx valid", o_vx_valid, 1'b1);
			check("vx data", o_vx_data, swap(D));
		end
		pm(1'b0, 2'h3, 32'h20, 32'h20, o_vx_data, D);
		finish_test();
	end
endmodule
`default_nettype wire
